// *** hw/rts_map.svh ***
`ifndef RTS_MAP_SVH
`define RTS_MAP_SVH
// Register indices; byte address is four times the index
`define RTS_IDX_STATUS 10'h003
`define RTS_IDX_POWER_CONTROL_STATUS 10'h08E
`define RTS_IDX_CFG 10'h090
`define RTS_IDX_IRQ_ST 10'h091
`define RTS_IDX_IRQ_MSK 10'h092
// Field positions
`define RTS_ST_TO 4
`define RTS_ST_PD 3
`define RTS_PC_POR 1
`define RTS_PC_BOR 0
`define RTS_CFG_POWER_UP_TIMER 2
`define RTS_IRQ_BOR 0
`define RTS_IRQ_WDT 1
`define RTS_IRQ_PIN 2
`define RTS_IRQ_WAKE 3
// Reset value and program counter vectors
`define RTS_CFG_RST 3'h4
`define RTS_VEC_RESET 13'h0000
`define RTS_VEC_IRQ 13'h0004
// Timing
`define RTS_CLK_MHZ 25
`define RTS_POWER_UP_DELAY_US 72000
`define RTS_TPLL_US 2000
`define RTS_BROWNOUT_MIN_DURATION_US 100
`define RTS_OST_CYC 1024
`endif

// *** hw/rts_pkg.sv ***
package rts_pkg;
	typedef enum logic [6:0] {
		RTS_S_HOLD = 7'h01,
		RTS_S_POWER_UP_TIMER = 7'h02,
		RTS_S_PLL = 7'h04,
		RTS_S_OST = 7'h08,
		RTS_S_PIN = 7'h10,
		RTS_S_RUN = 7'h20,
		RTS_S_SLEEP = 7'h40
	} rts_state_t;
	typedef enum logic [1:0] {
		RTS_OSC_XTAL = 2'h0,
		RTS_OSC_EXT = 2'h1,
		RTS_OSC_XTAL_PLL = 2'h2,
		RTS_OSC_EXT_PLL = 2'h3
	} rts_osc_t;
endpackage

// *** hw/rts_delay_cnt.sv ***
`timescale 1ns/1ps
module rts_delay_cnt (
	input wire logic mclk_i, // Clock
	input wire logic rst_b_i, // Async reset, active low
	input wire logic start_i, // Load and start counting
	input wire logic [20:0] load_i, // Delay in cycles, at least one
	output logic done_o // High in the last cycle of the delay
);
	logic [20:0] cnt_r;
	logic busy_r;

	// Down counter; a new start aborts any delay in flight
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r <= 21'h000000;
			busy_r <= 1'b0;
		end else if (start_i) begin
			cnt_r <= load_i - 21'h000001;
			busy_r <= 1'b1;
		end else if (busy_r) begin
			if (cnt_r == 21'h000000) begin
				busy_r <= 1'b0;
			end else begin
				cnt_r <= cnt_r - 21'h000001;
			end
		end
	end

	assign done_o = busy_r && (cnt_r == 21'h000000);
endmodule // rts_delay_cnt

// *** hw/rts_sequencer.sv ***
`timescale 1ns/1ps
`include "rts_map.svh"
// How it works
// - Low supply beyond minimum duration causes reset
// - Hold until supply recovers, then power-up delay
// - Dip during power-up delay restarts sequence
// - Brown-out detection can never be disabled
// - Timer disabled: no power-up delay after brown-out
// - Power-on: timer, then 1024 crystal cycles
// - Pin held past delays: run at release
// - Brown-out flag cleared by brown-out and power-on
// - Power-on flag cleared only by power-on
// - Delay set by oscillator mode and cause
// - Power-on sets time-out and power-down flags
// - Pin-in-sleep or interrupt wake: TO=1, PD=0
// - Every reset loads address zero; pin keeps flags
// - Wake resumes next address or interrupt vector
// - Resets default registers; wakes keep them
// - Wake sets its own bit in interrupt flags
// - Crystal start count on power-on, brown-out, wake
// - Watchdog time-out clears the time-out flag
module rts_sequencer #(
	parameter int unsigned POWER_UP_TIMER_CYC = `RTS_POWER_UP_DELAY_US * `RTS_CLK_MHZ, // Power-up delay
	parameter int unsigned PLL_CYC = `RTS_TPLL_US * `RTS_CLK_MHZ // PLL lock delay
) (
	input wire logic mclk_i, // 25 MHz clock
	input wire logic rst_b_i, // Power-on reset, active low
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write
	input wire logic [11:0] wb_adr_i, // Wishbone byte address
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic vdd_low_i, // Supply below brownout_threshold
	input wire logic external_reset_pin_n_i, // Reset pin, active low
	input wire logic wdt_timeout_i, // Watchdog time-out pulse
	input wire logic sleep_i, // Core executes sleep
	input wire logic irq_wake_i, // Enabled interrupt pending
	input wire logic global_interrupt_enable_i, // Core interrupt enable
	input wire logic [12:0] next_pc_i, // Address after sleep
	output logic core_reset_o, // Core and registers in reset
	output logic core_stall_o, // Core clock stopped
	output logic pc_load_o, // Load program counter pulse
	output logic [12:0] pc_value_o, // Program counter value
	output logic [1:0] wake_src_o, // Wake source pulse: 1 irq, 0 wdt
	output logic irq_o // Interrupt, level
);
	localparam int unsigned BOR_CYC = `RTS_BROWNOUT_MIN_DURATION_US * `RTS_CLK_MHZ;
	localparam logic [20:0] POWER_UP_TIMER_LD = 21'(POWER_UP_TIMER_CYC);
	localparam logic [20:0] PLL_LD = 21'(PLL_CYC);
	localparam logic [20:0] OST_LD = 21'(`RTS_OST_CYC);
	localparam logic [11:0] BOR_LAST = 12'(BOR_CYC - 1);

	rts_pkg::rts_state_t state_r;
	rts_pkg::rts_state_t state_nxt;
	logic [11:0] bor_cnt_r;
	logic [2:0] cfg_r;
	logic [3:0] irq_st_r;
	logic [3:0] irq_mask_r;
	logic to_r;
	logic pd_r;
	logic por_flag_r;
	logic bor_flag_r;
	logic wake_r;
	logic wake_irq_r;
	logic cnt_start;
	logic cnt_done;
	logic [20:0] cnt_load;
	logic pin_low;
	logic bor_trip;
	logic bor_evt;
	logic wdt_rst_evt;
	logic pin_evt;
	logic wake_go;
	logic wk_irq;
	logic bus_req;
	logic bus_wr;
	logic [9:0] idx;
	logic [7:0] rd_byte;

	// Next sequence step after a given stage, skipping stages that do not apply
	function automatic rts_pkg::rts_state_t rts_seq(input logic [1:0] lvl, input logic [2:0] cfg,
			input logic wake, input logic pin);
		rts_seq = (pin && !wake) ? rts_pkg::RTS_S_PIN : rts_pkg::RTS_S_RUN;
		if (lvl <= 2'h2 && !cfg[0]) begin
			rts_seq = rts_pkg::RTS_S_OST;
		end
		if (lvl <= 2'h1 && cfg[1]) begin
			rts_seq = rts_pkg::RTS_S_PLL;
		end
		if (lvl == 2'h0 && cfg[`RTS_CFG_POWER_UP_TIMER] && !wake) begin
			rts_seq = rts_pkg::RTS_S_POWER_UP_TIMER;
		end
	endfunction

	assign pin_low = !external_reset_pin_n_i;
	assign idx = wb_adr_i[11:2];
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

	// Event decode; a dip during the power-up delay trips at once
	assign bor_trip = vdd_low_i && ((bor_cnt_r == BOR_LAST)
		|| (state_r == rts_pkg::RTS_S_POWER_UP_TIMER));
	assign bor_evt = bor_trip && (state_r != rts_pkg::RTS_S_HOLD);
	assign pin_evt = !bor_trip && pin_low
		&& (state_r == rts_pkg::RTS_S_RUN || state_r == rts_pkg::RTS_S_SLEEP);
	assign wdt_rst_evt = !bor_trip && !pin_low && wdt_timeout_i
		&& (state_r == rts_pkg::RTS_S_RUN);
	assign wake_go = !bor_trip && !pin_low && (wdt_timeout_i || irq_wake_i)
		&& (state_r == rts_pkg::RTS_S_SLEEP);
	assign wk_irq = wake_go ? irq_wake_i : wake_irq_r;

	// Brown-out filter: supply must stay low for the minimum duration
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bor_cnt_r <= 12'h000;
		end else if (!vdd_low_i) begin
			bor_cnt_r <= 12'h000;
		end else if (bor_cnt_r != BOR_LAST) begin
			bor_cnt_r <= bor_cnt_r + 12'h001;
		end
	end

	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		if (bor_trip) begin
			state_nxt = rts_pkg::RTS_S_HOLD;
		end else begin
			case (state_r)
				rts_pkg::RTS_S_HOLD: begin
					if (!vdd_low_i) begin
						state_nxt = rts_seq(2'h0, cfg_r, 1'b0, pin_low);
					end
				end
				rts_pkg::RTS_S_POWER_UP_TIMER: begin
					if (cnt_done) begin
						state_nxt = rts_seq(2'h1, cfg_r, 1'b0, pin_low);
					end
				end
				rts_pkg::RTS_S_PLL: begin
					if (cnt_done) begin
						state_nxt = rts_seq(2'h2, cfg_r, wake_r, pin_low);
					end
				end
				rts_pkg::RTS_S_OST: begin
					if (cnt_done) begin
						state_nxt = rts_seq(2'h3, cfg_r, wake_r, pin_low);
					end
				end
				rts_pkg::RTS_S_PIN: begin
					if (!pin_low) begin
						state_nxt = rts_pkg::RTS_S_RUN;
					end
				end
				rts_pkg::RTS_S_RUN: begin
					if (pin_evt || wdt_rst_evt) begin
						state_nxt = rts_pkg::RTS_S_PIN;
					end else if (sleep_i) begin
						state_nxt = rts_pkg::RTS_S_SLEEP;
					end
				end
				rts_pkg::RTS_S_SLEEP: begin
					if (pin_evt) begin
						state_nxt = rts_pkg::RTS_S_PIN;
					end else if (wake_go) begin
						state_nxt = rts_seq(2'h1, cfg_r, 1'b1, 1'b0);
					end
				end
				default: begin
					state_nxt = rts_pkg::RTS_S_HOLD;
				end
			endcase
		end
	end

	// Delay counter load on entry to each timed stage
	always_comb begin
		cnt_load = OST_LD;
		case (state_nxt)
			rts_pkg::RTS_S_POWER_UP_TIMER: cnt_load = POWER_UP_TIMER_LD;
			rts_pkg::RTS_S_PLL: cnt_load = PLL_LD;
			default: cnt_load = OST_LD;
		endcase
		cnt_start = (state_nxt != state_r) && (state_nxt == rts_pkg::RTS_S_POWER_UP_TIMER
			|| state_nxt == rts_pkg::RTS_S_PLL || state_nxt == rts_pkg::RTS_S_OST);
	end

	rts_delay_cnt u_delay (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.start_i(cnt_start),
		.load_i(cnt_load),
		.done_o(cnt_done)
	);

	// Sequencer state; power-on starts in hold
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r <= rts_pkg::RTS_S_HOLD;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Wake bookkeeping, kept across the wake delays
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wake_r <= 1'b0;
			wake_irq_r <= 1'b0;
		end else if (wake_go) begin
			wake_r <= 1'b1;
			wake_irq_r <= irq_wake_i;
		end else if (state_r == rts_pkg::RTS_S_RUN || state_nxt == rts_pkg::RTS_S_RUN
				|| state_nxt == rts_pkg::RTS_S_HOLD || state_nxt == rts_pkg::RTS_S_PIN) begin
			wake_r <= 1'b0;
			wake_irq_r <= 1'b0;
		end
	end

	// Time-out and power-down flags
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			to_r <= 1'b1;
			pd_r <= 1'b1;
		end else if (bor_evt) begin
			to_r <= 1'b1;
			pd_r <= 1'b1;
		end else if (wdt_rst_evt) begin
			to_r <= 1'b0;
			pd_r <= 1'b1;
		end else if (wake_go && !irq_wake_i) begin
			to_r <= 1'b0;
			pd_r <= 1'b0;
		end else if ((pin_evt && state_r == rts_pkg::RTS_S_SLEEP) || wake_go) begin
			to_r <= 1'b1;
			pd_r <= 1'b0;
		end else if (state_r == rts_pkg::RTS_S_RUN && state_nxt == rts_pkg::RTS_S_SLEEP) begin
			to_r <= 1'b1;
			pd_r <= 1'b0;
		end
	end

	// Power control flags; hardware clear wins over a software set
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			por_flag_r <= 1'b0;
			bor_flag_r <= 1'b0;
		end else begin
			if (bor_evt) begin
				bor_flag_r <= 1'b0;
			end else if (bus_wr && idx == `RTS_IDX_POWER_CONTROL_STATUS) begin
				bor_flag_r <= wb_dat_i[`RTS_PC_BOR];
			end
			if (bus_wr && idx == `RTS_IDX_POWER_CONTROL_STATUS) begin
				por_flag_r <= wb_dat_i[`RTS_PC_POR];
			end
		end
	end

	// Configuration and interrupt mask
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_r <= `RTS_CFG_RST;
			irq_mask_r <= 4'h0;
		end else if (bus_wr) begin
			if (idx == `RTS_IDX_CFG) begin
				cfg_r <= wb_dat_i[2:0];
			end
			if (idx == `RTS_IDX_IRQ_MSK) begin
				irq_mask_r <= wb_dat_i[3:0];
			end
		end
	end

	// Sticky event status, write one to clear, set wins
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_st_r <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (bus_wr && idx == `RTS_IDX_IRQ_ST && wb_dat_i[i]) begin
					irq_st_r[i] <= 1'b0;
				end
			end
			if (bor_evt) begin
				irq_st_r[`RTS_IRQ_BOR] <= 1'b1;
			end
			if (wdt_rst_evt) begin
				irq_st_r[`RTS_IRQ_WDT] <= 1'b1;
			end
			if (pin_evt) begin
				irq_st_r[`RTS_IRQ_PIN] <= 1'b1;
			end
			if (wake_go) begin
				irq_st_r[`RTS_IRQ_WAKE] <= 1'b1;
			end
		end
	end

	// Read mux; unmapped indices read zero
	always_comb begin
		case (idx)
			`RTS_IDX_STATUS: rd_byte = {3'h0, to_r, pd_r, 3'h0};
			`RTS_IDX_POWER_CONTROL_STATUS: rd_byte = {6'h00, por_flag_r, bor_flag_r};
			`RTS_IDX_CFG: rd_byte = {5'h00, cfg_r};
			`RTS_IDX_IRQ_ST: rd_byte = {4'h0, irq_st_r};
			`RTS_IDX_IRQ_MSK: rd_byte = {4'h0, irq_mask_r};
			default: rd_byte = 8'h00;
		endcase
	end

	// Bus answer one cycle after the strobe, every address
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i) begin
				wb_dat_o <= {24'h000000, rd_byte};
			end
		end
	end

	// Core controls, all registered; irq and wake source do not follow the next state
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			core_reset_o <= 1'b1;
			core_stall_o <= 1'b0;
			pc_load_o <= 1'b0;
			pc_value_o <= `RTS_VEC_RESET;
			wake_src_o <= 2'h0;
			irq_o <= 1'b0;
		end else begin
			core_reset_o <= !(state_nxt == rts_pkg::RTS_S_RUN
				|| state_nxt == rts_pkg::RTS_S_SLEEP || (wake_r || wake_go)
				&& state_nxt != rts_pkg::RTS_S_HOLD && state_nxt != rts_pkg::RTS_S_PIN);
			core_stall_o <= (state_nxt == rts_pkg::RTS_S_SLEEP)
				|| ((wake_r || wake_go) && state_nxt != rts_pkg::RTS_S_RUN);
			pc_load_o <= (state_nxt == rts_pkg::RTS_S_RUN) && (state_r != rts_pkg::RTS_S_RUN);
			if ((wake_r || wake_go) && state_nxt != rts_pkg::RTS_S_HOLD
					&& state_nxt != rts_pkg::RTS_S_PIN) begin
				pc_value_o <= (wk_irq && global_interrupt_enable_i)
					? `RTS_VEC_IRQ : next_pc_i;
			end else begin
				pc_value_o <= `RTS_VEC_RESET;
			end
			wake_src_o <= wake_go ? {irq_wake_i, !irq_wake_i} : 2'h0;
			irq_o <= |(irq_st_r & irq_mask_r);
		end
	end
endmodule // rts_sequencer

// *** bench/rts_sequencer_sva.sv ***
`timescale 1ns/1ps
module rts_sequencer_sva #(
	parameter int unsigned POWER_UP_TIMER_CYC = 20, // Power-up delay
	parameter int unsigned PLL_CYC = 10 // PLL lock delay
) (
	input wire logic mclk_i, // Clock
	input wire logic rst_b_i, // Reset
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_ack_o, // Ack
	input wire logic vdd_low_i, // Low supply
	input wire logic external_reset_pin_n_i, // Pin
	input wire logic core_reset_o, // Core reset
	input wire logic core_stall_o, // Stall
	input wire logic pc_load_o, // Load pulse
	input wire logic [12:0] pc_value_o, // Address
	input wire logic [1:0] wake_src_o // Wake source
);
	logic [11:0] low_cnt_r;
	logic [20:0] hold_cnt_r;
	// Longest start-up: power-up, PLL, 1024-cycle count and a few cycles of slack
	localparam logic [20:0] HOLD_MAX = 21'(POWER_UP_TIMER_CYC + PLL_CYC + 1030);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	// Cycles of continuous low supply
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			low_cnt_r <= 12'h000;
		end else if (!vdd_low_i) begin
			low_cnt_r <= 12'h000;
		end else if (low_cnt_r != 12'hFFF) begin
			low_cnt_r <= low_cnt_r + 12'h001;
		end
	end
	// Cycles of core reset with supply good and pin released
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hold_cnt_r <= 21'h000000;
		end else if (!core_reset_o || vdd_low_i || !external_reset_pin_n_i) begin
			hold_cnt_r <= 21'h000000;
		end else if (hold_cnt_r != 21'h1FFFFF) begin
			hold_cnt_r <= hold_cnt_r + 21'h000001;
		end
	end
	property p_hold; hold_cnt_r <= HOLD_MAX; endproperty
	a_hold: assert property (p_hold) else $error("reset held too long");
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack1: assert property (p_ack1) else $error("long ack");
	property p_bor; low_cnt_r > 12'h9CE |-> core_reset_o; endproperty
	a_bor: assert property (p_bor) else $error("no brownout reset");
	property p_pin; !external_reset_pin_n_i && core_reset_o |=> core_reset_o; endproperty
	a_pin: assert property (p_pin) else $error("released with pin low");
	property p_pin_go; $fell(external_reset_pin_n_i) && !core_stall_o && !core_reset_o |=> core_reset_o; endproperty
	a_pin_go: assert property (p_pin_go) else $error("pin ignored");
	property p_rel; $fell(core_reset_o) |-> pc_load_o && pc_value_o == 13'h0000; endproperty
	a_rel: assert property (p_rel) else $error("bad start address");
	property p_pld; pc_load_o |=> !pc_load_o; endproperty
	a_pld: assert property (p_pld) else $error("long load");
	property p_src; wake_src_o != 2'b00 |=> wake_src_o == 2'b00; endproperty
	a_src: assert property (p_src) else $error("long wake source");
	property p_wk; wake_src_o != 2'b00 |-> !core_reset_o; endproperty
	a_wk: assert property (p_wk) else $error("wake resets core");
endmodule // rts_sequencer_sva
bind rts_sequencer rts_sequencer_sva #(.POWER_UP_TIMER_CYC(POWER_UP_TIMER_CYC), .PLL_CYC(PLL_CYC)) rts_sequencer_sva_inst (
	.mclk_i(mclk_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.vdd_low_i(vdd_low_i), .external_reset_pin_n_i(external_reset_pin_n_i), .core_reset_o(core_reset_o),
	.core_stall_o(core_stall_o), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o), .wake_src_o(wake_src_o));

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
	localparam int PW = 20;
	localparam int PL = 10;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic req = 1'b0;
	logic we = 1'b0;
	logic vlow = 1'b0;
	logic pin_n = 1'b1;
	logic wdt = 1'b0;
	logic slp = 1'b0;
	logic wk = 1'b0;
	logic global_interrupt_enable = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [31:0] wd = 32'h00000000;
	logic [3:0] sel = 4'h0;
	logic [12:0] npc = 13'h0000;
	logic [31:0] rd;
	logic ack, crst, stall, pld, irq;
	logic [12:0] pcv, pc_seen;
	logic [1:0] wsrc, src_seen;
	logic [7:0] q;
	int miscompares = 0;
	int checked = 0;
	int cyc_n = 0;
	int n, d, to_f, pd_f, pc_f;
	always #20 mclk = ~mclk;
	rts_sequencer #(.POWER_UP_TIMER_CYC(PW), .PLL_CYC(PL)) rts_sequencer_inst (
		.mclk_i(mclk), .rst_b_i(rst_b), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(wd), .wb_sel_i(sel), .wb_dat_o(rd), .wb_ack_o(ack), .vdd_low_i(vlow),
		.external_reset_pin_n_i(pin_n), .wdt_timeout_i(wdt), .sleep_i(slp), .irq_wake_i(wk),
		.global_interrupt_enable_i(global_interrupt_enable), .next_pc_i(npc), .core_reset_o(crst), .core_stall_o(stall),
		.pc_load_o(pld), .pc_value_o(pcv), .wake_src_o(wsrc), .irq_o(irq));
	// Run limit
	always @(posedge mclk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			miscompares++;
			results();
		end
	end
	task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] s);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask
	// One classic cycle; read data kept in q
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] dt);
		req <= 1'b1;
		we <= w;
		sel <= 4'hF;
		adr <= a;
		wd <= {24'h000000, dt};
		@(posedge mclk);
		while (ack !== 1'b1) begin
			@(posedge mclk);
		end
		q = rd[7:0];
		req <= 1'b0;
		sel <= 4'h0;
		@(posedge mclk);
	endtask
	task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(nm, 13'(e), 13'(q & m));
	endtask
	task automatic flags();
		rdc("status", 12'h00C, 8'h18, 8'(to_f * 16 + pd_f * 8));
		rdc("power_control_status", 12'h238, 8'h03, 8'(pc_f));
	endtask
	// Event bit raises the line when unmasked, clears on write-one
	task automatic evt(input int b);
		chk("irq_masked", 13'h0000, 13'(irq));
		bus(1'b1, 12'h248, 8'(1 << b));
		chk("irq_set", 13'h0001, 13'(irq));
		bus(1'b1, 12'h244, 8'hFF);
		chk("irq_clr", 13'h0000, 13'(irq));
		rdc("irq_st", 12'h244, 8'hFF, 8'h00);
		bus(1'b1, 12'h248, 8'h00);
	endtask
	task automatic run_wait();
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			if (wsrc !== 2'b00) begin
				src_seen = wsrc;
			end
		end while (pld !== 1'b1);
		pc_seen = pcv;
	endtask
	task automatic results();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Main sequence
	initial begin
		void'($urandom(80));
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		to_f = 1;
		pd_f = 1;
		pc_f = 0;
		run_wait();
		chk("por_dly", 13'h0001, 13'(n >= PW + 1024 && n <= PW + 1032));
		chk("por_pc", 13'h0000, pc_seen);
		flags();
		bus(1'b1, 12'h238, 8'h03);
		bus(1'b1, 12'h00C, 8'h00);
		pc_f = 3;
		flags();
		rdc("unmapped", 12'h100, 8'hFF, 8'h00);
		for (int m = 0; m < 5; m++) begin
			global_interrupt_enable <= (m < 2) ? 1'(m) : 1'($urandom);
			npc <= 13'($urandom);
			d = (m[1] ? PL : 0) + (m[0] ? 0 : 1024);
			bus(1'b1, 12'h240, 8'(4 | (m & 3)));
			slp <= 1'b1;
			@(posedge mclk);
			slp <= 1'b0;
			repeat (3) @(posedge mclk);
			chk("sleep_stall", 13'h0001, 13'(stall));
			chk("sleep_rst", 13'h0000, 13'(crst));
			src_seen = 2'b00;
			if (m < 4)
				wk <= 1'b1;
			else
				wdt <= 1'b1;
			@(posedge mclk);
			wk <= 1'b0;
			wdt <= 1'b0;
			run_wait();
			to_f = (m < 4);
			pd_f = 0;
			chk("wake_dly", 13'h0001, 13'(n >= d && n <= d + 4));
			chk("run_stall", 13'h0000, 13'(stall));
			chk("wake_pc", (m < 4 && global_interrupt_enable) ? 13'h0004 : npc, pc_seen);
			chk("wake_src", (m < 4) ? 13'h0002 : 13'h0001, 13'(src_seen));
			flags();
			evt(3);
		end
		wdt <= 1'b1;
		@(posedge mclk);
		wdt <= 1'b0;
		run_wait();
		to_f = 0;
		pd_f = 1;
		chk("wdt_dly", 13'h0001, 13'(n <= 4));
		chk("wdt_pc", 13'h0000, pc_seen);
		flags();
		evt(1);
		pin_n <= 1'b0;
		repeat (3) @(posedge mclk);
		pin_n <= 1'b1;
		run_wait();
		chk("pin_pc", 13'h0000, pc_seen);
		chk("pin_dly", 13'h0001, 13'(n <= 3));
		flags();
		evt(2);
		rst_b <= 1'b0;
		pin_n <= 1'b0;
		@(posedge mclk);
		rst_b <= 1'b1;
		to_f = 1;
		pd_f = 1;
		pc_f = 0;
		repeat (PW + 1100) @(posedge mclk);
		chk("pin_hold", 13'h0001, 13'(crst));
		pin_n <= 1'b1;
		run_wait();
		chk("pin_rel", 13'h0001, 13'(n <= 3));
		flags();
		bus(1'b1, 12'h238, 8'h03);
		vlow <= 1'b1;
		repeat (100) @(posedge mclk);
		vlow <= 1'b0;
		@(posedge mclk);
		chk("short_dip", 13'h0000, 13'(crst));
		vlow <= 1'b1;
		repeat (2600) @(posedge mclk);
		chk("bor_on", 13'h0001, 13'(crst));
		vlow <= 1'b0;
		repeat (10) @(posedge mclk);
		vlow <= 1'b1;
		repeat (5) @(posedge mclk);
		vlow <= 1'b0;
		run_wait();
		chk("bor_dly", 13'h0001, 13'(n >= PW + 1024 && n <= PW + 1030));
		pc_f = 2;
		flags();
		evt(0);
		bus(1'b1, 12'h240, 8'h00);
		vlow <= 1'b1;
		repeat (2600) @(posedge mclk);
		vlow <= 1'b0;
		run_wait();
		chk("bor_nopwrt", 13'h0001, 13'(n >= 1024 && n <= 1030));
		results();
	end
endmodule // tb
